// ===== logic/lcdi_pkg.sv
package lcdi_pkg;
  // Slave identifiers
  localparam logic [6:0] ID_CONTROL = 7'h38;
  localparam logic [6:0] ID_SEGMENT = 7'h39;
  // Frame layout
  localparam int unsigned BITS_PER_BYTE = 8;
  localparam logic [3:0] BIT_COUNT_DATA = 4'h8;
  localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
  localparam int unsigned ID_MSB = 7;
  localparam int unsigned DIR_BIT = 0;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] ADDR_STEP = 8'h01;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h3;

  typedef enum logic [2:0] {
    LCDI_IDLE = 3'b000,
    LCDI_ID = 3'b001,
    LCDI_ADDR = 3'b010,
    LCDI_WDATA = 3'b011,
    LCDI_TX = 3'b100,
    LCDI_ACK = 3'b101,
    LCDI_MACK = 3'b110,
    LCDI_IGNORE = 3'b111
  } lcdi_state_t;
endpackage : lcdi_pkg

// ===== logic/lcdi_mem_if.sv
`timescale 1ns/100ps
interface lcdi_mem_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic space_seg;
  logic [AW-1:0] addr;
  logic wr_en;
  logic [DW-1:0] wr_data;
  logic [DW-1:0] rd_data;
  modport master (output space_seg, output addr, output wr_en,
    output wr_data, input rd_data);
  modport slave (input space_seg, input addr, input wr_en,
    input wr_data, output rd_data);
endinterface : lcdi_mem_if

// ===== logic/lcdi_regs.sv
`timescale 1ns/100ps
module lcdi_regs #(
  parameter int DEPTH = 256
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  lcdi_mem_if.slave mem
);
  logic [7:0] ctl_mem [DEPTH];
  logic [7:0] seg_mem [DEPTH];

  // Address is one byte wide, so only a full 256-entry space fits
  if (DEPTH != 256) begin : g_bad_depth
    $error("lcdi_regs: DEPTH must be 256");
  end

  // ---------------------------------------------------------------
  // Two storage spaces
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (ce_i && mem.wr_en) begin
      if (mem.space_seg) begin
        seg_mem[mem.addr] <= mem.wr_data;
      end else begin
        ctl_mem[mem.addr] <= mem.wr_data;
      end
    end
  end

  // Read is combinational; sampled by the shifter when loaded
  assign mem.rd_data = mem.space_seg ? seg_mem[mem.addr] : ctl_mem[mem.addr];
endmodule : lcdi_regs

// ===== logic/lcdi_i2c_slave.sv
`timescale 1ns/100ps
// Operation
// - Seven ID bits after start pick control space or segment memory.
// - Eighth bit is direction; zero means master writes.
// - Device pulls SDA low on ninth clock after a matching ID byte and each byte received after it.
// - First byte after ID in write frame is start address, MSB first.
// - Each write data byte is stored at the current address.
// - Address increments by one after each byte read or written.
// - Read uses write frame for address, restart, same ID; address kept.
// - Direction one after repeated ID is acknowledged, then transmit mode.
// - Transmit mode drives current address byte on clocks one to eight.
// - Master acknowledge low requests the next incremented byte.
// - No master acknowledge ends the read and releases SDA.
// - Reset releases SDA and returns interface to idle.
// - Matched device stays selected until next start, stop or unacknowledged read byte.
module lcdi_i2c_slave (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  lcdi_mem_if #(.AW(8), .DW(8)) mem ();

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scl_sync <= lcdi_pkg::SYNC_RESET;
      sda_sync <= lcdi_pkg::SYNC_RESET;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce_i) begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_sync[1] && !scl_q;
  assign scl_fall = !scl_sync[1] && scl_q;
  assign start_det = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
  assign stop_det = scl_sync[1] && scl_q && !sda_q && sda_sync[1];

  // ---------------------------------------------------------------
  // Frame state
  // ---------------------------------------------------------------
  lcdi_pkg::lcdi_state_t state;
  lcdi_pkg::lcdi_state_t ack_next;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] addr;
  logic space_seg;
  logic dir_read;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] tx_byte;
  logic mack_low;

  logic [7:0] rx_byte;
  assign rx_byte = {shift[6:0], sda_sync[1]};

  // Match latched at the eighth rise so the ninth-clock decision is stable
  logic id_match_q;

  logic id_match;
  assign id_match = (rx_byte[lcdi_pkg::ID_MSB:1] == lcdi_pkg::ID_CONTROL)
    || (rx_byte[lcdi_pkg::ID_MSB:1] == lcdi_pkg::ID_SEGMENT);

  // Bit counter and shifter
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bit_cnt <= lcdi_pkg::BIT_COUNT_ZERO;
      shift <= lcdi_pkg::DATA_RESET;
    end else if (ce_i) begin
      if (start_det || (scl_fall && state == lcdi_pkg::LCDI_ACK)) begin
        bit_cnt <= lcdi_pkg::BIT_COUNT_ZERO;
      end else if (scl_fall && state == lcdi_pkg::LCDI_MACK) begin
        bit_cnt <= lcdi_pkg::BIT_COUNT_ZERO;
      end else if (scl_rise && bit_cnt != lcdi_pkg::BIT_COUNT_DATA) begin
        shift <= rx_byte;
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // Main sequencer; decisions at the falling edge after bit eight
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= lcdi_pkg::LCDI_IDLE;
      ack_next <= lcdi_pkg::LCDI_IDLE;
      space_seg <= 1'b0;
      dir_read <= 1'b0;
    end else if (ce_i) begin
      if (start_det) begin
        state <= lcdi_pkg::LCDI_ID;
      end else if (stop_det) begin
        state <= lcdi_pkg::LCDI_IDLE;
      end else if (scl_fall) begin
        case (state)
          lcdi_pkg::LCDI_ID: begin
            if (bit_cnt == lcdi_pkg::BIT_COUNT_DATA) begin
              if (id_match_q) begin
                space_seg <= shift[1];
                dir_read <= shift[lcdi_pkg::DIR_BIT] != lcdi_pkg::DIR_WRITE;
                state <= lcdi_pkg::LCDI_ACK;
                if (shift[lcdi_pkg::DIR_BIT] == lcdi_pkg::DIR_WRITE) begin
                  ack_next <= lcdi_pkg::LCDI_ADDR;
                end else begin
                  ack_next <= lcdi_pkg::LCDI_TX;
                end
              end else begin
                state <= lcdi_pkg::LCDI_IGNORE;
              end
            end
          end
          lcdi_pkg::LCDI_ADDR: begin
            if (bit_cnt == lcdi_pkg::BIT_COUNT_DATA) begin
              state <= lcdi_pkg::LCDI_ACK;
              ack_next <= lcdi_pkg::LCDI_WDATA;
            end
          end
          lcdi_pkg::LCDI_WDATA: begin
            if (bit_cnt == lcdi_pkg::BIT_COUNT_DATA) begin
              state <= lcdi_pkg::LCDI_ACK;
              ack_next <= lcdi_pkg::LCDI_WDATA;
            end
          end
          lcdi_pkg::LCDI_ACK: begin
            state <= ack_next;
          end
          lcdi_pkg::LCDI_TX: begin
            if (bit_cnt == lcdi_pkg::BIT_COUNT_DATA) begin
              state <= lcdi_pkg::LCDI_MACK;
            end
          end
          lcdi_pkg::LCDI_MACK: begin
            if (mack_low) begin
              state <= lcdi_pkg::LCDI_TX;
            end else begin
              state <= lcdi_pkg::LCDI_IGNORE;
            end
          end
          lcdi_pkg::LCDI_IDLE: begin
            state <= lcdi_pkg::LCDI_IDLE;
          end
          lcdi_pkg::LCDI_IGNORE: begin
            state <= lcdi_pkg::LCDI_IGNORE;
          end
          default: begin
            state <= lcdi_pkg::LCDI_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Slave match capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      id_match_q <= 1'b0;
    end else if (ce_i && scl_rise && state == lcdi_pkg::LCDI_ID
        && bit_cnt == (lcdi_pkg::BIT_COUNT_DATA - 4'h1)) begin
      id_match_q <= id_match;
    end
  end

  // Master acknowledge sampled on the ninth rising edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mack_low <= 1'b0;
    end else if (ce_i && scl_rise && state == lcdi_pkg::LCDI_MACK) begin
      mack_low <= !sda_sync[1];
    end
  end

  // ---------------------------------------------------------------
  // Address pointer; held across restart, not cleared by start
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      addr <= lcdi_pkg::ADDR_RESET;
    end else if (ce_i && scl_fall && !start_det && !stop_det) begin
      if (state == lcdi_pkg::LCDI_ADDR
          && bit_cnt == lcdi_pkg::BIT_COUNT_DATA) begin
        addr <= shift;
      end else if (state == lcdi_pkg::LCDI_WDATA
          && bit_cnt == lcdi_pkg::BIT_COUNT_DATA) begin
        addr <= addr + lcdi_pkg::ADDR_STEP;
      end else if (state == lcdi_pkg::LCDI_TX
          && bit_cnt == lcdi_pkg::BIT_COUNT_DATA) begin
        addr <= addr + lcdi_pkg::ADDR_STEP;
      end
    end
  end

  // Write strobe, one cycle per received data byte
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_en <= 1'b0;
      wr_data <= lcdi_pkg::DATA_RESET;
    end else if (ce_i) begin
      wr_en <= scl_fall && !start_det && !stop_det
        && state == lcdi_pkg::LCDI_WDATA
        && bit_cnt == lcdi_pkg::BIT_COUNT_DATA;
      wr_data <= shift;
    end
  end

  // Write uses the pre-increment address, so the store is registered
  // together with its own address copy.
  logic [7:0] wr_addr;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_addr <= lcdi_pkg::ADDR_RESET;
    end else if (ce_i) begin
      wr_addr <= addr;
    end
  end

  assign mem.space_seg = space_seg;
  assign mem.addr = wr_en ? wr_addr : addr;
  assign mem.wr_en = wr_en;
  assign mem.wr_data = wr_data;

  lcdi_regs #(.DEPTH(256)) u_regs (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .mem(mem)
  );

  // ---------------------------------------------------------------
  // Transmit shifter: loaded when transmit begins, shifted per fall
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_byte <= lcdi_pkg::DATA_RESET;
    end else if (ce_i) begin
      if (state == lcdi_pkg::LCDI_TX && bit_cnt == lcdi_pkg::BIT_COUNT_ZERO
          && !scl_fall && !wr_en) begin
        tx_byte <= mem.rd_data;
      end else if (scl_fall && state == lcdi_pkg::LCDI_TX) begin
        tx_byte <= {tx_byte[6:0], 1'b1};
      end
    end
  end

  // Open drain: drive low only; reset releases the line
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sda_oe_o <= 1'b0;
    end else if (ce_i) begin
      case (state)
        lcdi_pkg::LCDI_ACK: sda_oe_o <= 1'b1;
        // Last bit held until its falling edge; never move SDA, SCL high
        lcdi_pkg::LCDI_TX:
          sda_oe_o <= !tx_byte[lcdi_pkg::BITS_PER_BYTE-1];
        default: sda_oe_o <= 1'b0;
      endcase
    end
  end

  assign sda_o = 1'b0;
endmodule : lcdi_i2c_slave

// ===== verif/lcdi_asserts.sv
`timescale 1ns/100ps
module lcdi_asserts (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  logic [9:0] run;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ----
  // Drive checks
  // ----
  // Longest legal drive is an ack then a zero byte, nine slow bits
  always_ff @(posedge clk_i) begin
    if (reset_i || !sda_oe_o) begin
      run <= 10'h000;
    end else if (run != 10'h3FF) begin
      run <= run + 10'h001;
    end
  end
  property p_rst; disable iff (!ce_i) reset_i |=> !sda_oe_o; endproperty
  a_rst: assert property (p_rst) else $error("drive after reset");
  property p_drain; sda_oe_o |-> !sda_o; endproperty
  a_drain: assert property (p_drain) else $error("sda not low");
  // Changing while SCL is high would fake a start or stop
  property p_edge; $changed(sda_oe_o) |-> !scl_i && !$past(scl_i)
    && !$past(scl_i, 2); endproperty
  a_edge: assert property (p_edge) else $error("sda moved, scl high");
  property p_hold; sda_oe_o && $rose(scl_i) |-> sda_oe_o [*8]; endproperty
  a_hold: assert property (p_hold) else $error("drive cut short");
  property p_min; $rose(sda_oe_o) |-> sda_oe_o [*8]; endproperty
  a_min: assert property (p_min) else $error("drive too short");
  property p_stop; scl_i && $past(scl_i) && $rose(sda_i) |->
    !sda_oe_o [*8]; endproperty
  a_stop: assert property (p_stop) else $error("drive after stop");
  property p_start; scl_i && $past(scl_i) && $fell(sda_i) |->
    !sda_oe_o [*8]; endproperty
  a_start: assert property (p_start) else $error("drive at start");
  property p_bound; run < 10'h140; endproperty
  a_bound: assert property (p_bound) else $error("sda held low");
endmodule : lcdi_asserts
bind lcdi_i2c_slave lcdi_asserts u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .ce_i(ce_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o));

// ===== verif/lcdi_host_model.sv
`timescale 1ns/100ps
module lcdi_host_model (
  input wire logic clk_i,
  input wire logic dev_oe_i,
  output logic scl_o,
  output logic sda_o
);
  // Quarter SCL period; raise it for a slow host
  int h = 5;
  logic drv = 1'b0;
  // Pull-up: a released line reads high
  assign sda_o = !(drv || dev_oe_i);
  initial scl_o = 1'b1;
  // ----
  // Bus phases
  // ----
  task automatic step(input logic s, input logic d);
    drv <= !d;
    scl_o <= s;
    repeat (h) @(posedge clk_i);
  endtask : step
  task automatic xbit(input logic b, output logic r);
    step(1'b0, b);
    step(1'b1, b);
    r = sda_o;
    step(1'b1, b);
    step(1'b0, b);
  endtask : xbit
  task automatic start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(last, r);
  endtask : rbyte
endmodule : lcdi_host_model

// ===== verif/lcd_driver_i2c_slave_access_tb.sv
`timescale 1ns/100ps
module lcd_driver_i2c_slave_access_tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic scl, sda, sda_o, sda_oe_o;
  logic [7:0] exp_mem [2][256];
  int num_errors = 0;
  int n_tests = 0;
  lcdi_i2c_slave dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
  lcdi_host_model mst (.clk_i(clk_i), .dev_oe_i(sda_oe_o), .scl_o(scl),
    .sda_o(sda));
  initial begin
    forever #4 clk_i = !clk_i;
  end
  // ----
  // Helpers
  // ----
  task automatic test_done();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_tests++;
    if (got !== want) begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  function automatic logic [7:0] idb(input logic s, input logic r);
    return {s ? lcdi_pkg::ID_SEGMENT : lcdi_pkg::ID_CONTROL, r};
  endfunction : idb
  task automatic wr(input logic s, input logic [7:0] a, input int n);
    logic k;
    logic [7:0] d;
    mst.start();
    mst.wbyte(idb(s, 1'b0), k);
    chk(8'(k), 8'h01);
    mst.wbyte(a, k);
    chk(8'(k), 8'h01);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      exp_mem[s][a + 8'(i)] = d;
      mst.wbyte(d, k);
      chk(8'(k), 8'h01);
    end
    mst.stop();
  endtask : wr
  task automatic rd(input logic s, input logic [7:0] a, input int n);
    logic k;
    logic [7:0] d;
    mst.start();
    mst.wbyte(idb(s, 1'b0), k);
    mst.wbyte(a, k);
    mst.start();
    mst.wbyte(idb(s, 1'b1), k);
    chk(8'(k), 8'h01);
    for (int i = 0; i < n; i++) begin
      mst.rbyte(i == n - 1, d);
      chk(d, exp_mem[s][a + 8'(i)]);
    end
    mst.xbit(1'b1, k);
    chk(8'(k), 8'h01);
    mst.stop();
  endtask : rd
  initial begin
    repeat (80000) @(posedge clk_i);
    num_errors++;
    test_done();
  end
  initial begin
    logic [7:0] a;
    logic k;
    logic [7:0] bad [3];
    bad = '{8'h74, 8'hF1, 8'h31};
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    void'($urandom(64921));
    for (int t = 0; t < 6; t++) begin
      mst.h = 5 + 3 * (t % 2);
      a = (t == 0) ? 8'h00 : (t == 1) ? 8'hFD : 8'($urandom_range(253));
      wr(1'b0, a, 3);
      wr(1'b1, a, 3);
      rd(1'b0, a, 3);
      rd(1'b1, a, t % 3 + 1);
      $display("Test %0d done", t);
    end
    foreach (bad[i]) begin
      mst.start();
      mst.wbyte(bad[i], k);
      chk(8'(k), 8'h00);
      mst.wbyte(8'h00, k);
      chk(8'(k), 8'h00);
      mst.stop();
    end
    $display("Test foreign id done");
    mst.h = 5;
    mst.start();
    // Reset lands while the ack holds the line low
    fork
      mst.wbyte(idb(1'b0, 1'b0), k);
      begin
        repeat (166) @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        chk(8'(sda_oe_o), 8'h00);
      end
    join
    mst.stop();
    wr(1'b0, a, 2);
    rd(1'b0, a, 2);
    $display("Test reset done");
    test_done();
  end
endmodule : lcd_driver_i2c_slave_access_tb
